// >>> otr_pkg.sv
// constants for the octal three-state register with clear
`default_nettype none
package otr_pkg;
	localparam int OTR_DATA_WIDTH = 8;
	localparam int OTR_OE_COUNT = 3;
	localparam int OTR_CTRL_WIDTH = 6;
	// control bundle layout: {enable_n, clear_n, edge_clock, oe_n[2:0]}
	localparam int OTR_POS_OE = 0;
	localparam int OTR_POS_CLOCK = 3;
	localparam int OTR_POS_CLEAR = 4;
	localparam int OTR_POS_ENABLE = 5;
	// idle pin levels: enables and clear inactive, clock low
	localparam logic [OTR_CTRL_WIDTH-1:0] OTR_CTRL_RESET = 6'h37;
	localparam logic OTR_STORE_RESET = 1'h0;
	localparam logic OTR_DRIVE_RESET = 1'h0;
endpackage
`default_nettype wire

// >>> otr_register.sv
// octal edge-triggered register with clear, load enable and gated outputs
`default_nettype none
module otr_register #(
	parameter int WIDTH = otr_pkg::OTR_DATA_WIDTH
) (
	// system
	input wire logic clock,
	input wire logic sys_rst,
	// parallel data side
	input wire logic [WIDTH-1:0] data_in,
	input wire logic edge_clock,
	input wire logic enable_n,
	input wire logic clear_n,
	// output enables
	input wire logic [otr_pkg::OTR_OE_COUNT-1:0] out_enable_n,
	// bus side
	output logic [WIDTH-1:0] bus_out,
	output logic [WIDTH-1:0] bus_oe
);
	import otr_pkg::*;

	// idle pin levels: data from the store reset value, controls unpacked from the packed control reset word
	localparam logic [WIDTH-1:0] DATA_IDLE = {WIDTH{OTR_STORE_RESET}};
	localparam logic CLOCK_IDLE = OTR_CTRL_RESET[OTR_POS_CLOCK];
	localparam logic CLEAR_IDLE = OTR_CTRL_RESET[OTR_POS_CLEAR];
	localparam logic ENABLE_IDLE = OTR_CTRL_RESET[OTR_POS_ENABLE];
	localparam logic [OTR_OE_COUNT-1:0] OE_IDLE =
		OTR_CTRL_RESET[OTR_POS_OE +: OTR_OE_COUNT];

	// a bit takes a new level once stage two and stage three agree
	function automatic logic otr_agree(
		input logic s2,
		input logic s3,
		input logic held
	);
		otr_agree = (s2 & s3) | (held & (s2 | s3));
	endfunction

	// data pins
	logic [WIDTH-1:0] data_s1_q;
	logic [WIDTH-1:0] data_s2_q;
	logic [WIDTH-1:0] data_s3_q;
	logic [WIDTH-1:0] data_f_q;
	logic [WIDTH-1:0] data_f_d;
	// storage clock pin
	logic edge_clock_s1_q;
	logic edge_clock_s2_q;
	logic edge_clock_s3_q;
	logic edge_clock_f_q;
	logic edge_clock_f_d;
	// load enable pin
	logic enable_n_s1_q;
	logic enable_n_s2_q;
	logic enable_n_s3_q;
	logic enable_n_f_q;
	logic enable_n_f_d;
	// clear pin
	logic clear_n_s1_q;
	logic clear_n_s2_q;
	logic clear_n_s3_q;
	logic clear_n_f_q;
	logic clear_n_f_d;
	// output enable pins
	logic [OTR_OE_COUNT-1:0] oe_n_s1_q;
	logic [OTR_OE_COUNT-1:0] oe_n_s2_q;
	logic [OTR_OE_COUNT-1:0] oe_n_s3_q;
	logic [OTR_OE_COUNT-1:0] oe_n_f_q;
	logic [OTR_OE_COUNT-1:0] oe_n_f_d;
	// storage and drive
	logic clock_rise;
	logic clear_act;
	logic load_ok;
	logic [WIDTH-1:0] store_q;
	logic [WIDTH-1:0] store_d;
	logic drive_d;
	logic drive_q;

	// data synchroniser
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			data_s1_q <= DATA_IDLE;
			data_s2_q <= DATA_IDLE;
			data_s3_q <= DATA_IDLE;
		end else begin
			data_s1_q <= data_in;
			data_s2_q <= data_s1_q;
			data_s3_q <= data_s2_q;
		end
	end

	// storage clock synchroniser, idles low so reset gives no false rise
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			edge_clock_s1_q <= CLOCK_IDLE;
			edge_clock_s2_q <= CLOCK_IDLE;
			edge_clock_s3_q <= CLOCK_IDLE;
		end else begin
			edge_clock_s1_q <= edge_clock;
			edge_clock_s2_q <= edge_clock_s1_q;
			edge_clock_s3_q <= edge_clock_s2_q;
		end
	end

	// load enable synchroniser
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			enable_n_s1_q <= ENABLE_IDLE;
			enable_n_s2_q <= ENABLE_IDLE;
			enable_n_s3_q <= ENABLE_IDLE;
		end else begin
			enable_n_s1_q <= enable_n;
			enable_n_s2_q <= enable_n_s1_q;
			enable_n_s3_q <= enable_n_s2_q;
		end
	end

	// clear synchroniser
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			clear_n_s1_q <= CLEAR_IDLE;
			clear_n_s2_q <= CLEAR_IDLE;
			clear_n_s3_q <= CLEAR_IDLE;
		end else begin
			clear_n_s1_q <= clear_n;
			clear_n_s2_q <= clear_n_s1_q;
			clear_n_s3_q <= clear_n_s2_q;
		end
	end

	// output enable synchroniser
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			oe_n_s1_q <= OE_IDLE;
			oe_n_s2_q <= OE_IDLE;
			oe_n_s3_q <= OE_IDLE;
		end else begin
			oe_n_s1_q <= out_enable_n;
			oe_n_s2_q <= oe_n_s1_q;
			oe_n_s3_q <= oe_n_s2_q;
		end
	end

	// agreement filters: pulses of a single clock cycle are dropped
	always_comb begin
		data_f_d = data_f_q;
		for (int i = 0; i < WIDTH; i++) begin
			data_f_d[i] = otr_agree(data_s2_q[i], data_s3_q[i],
				data_f_q[i]);
		end
	end

	always_comb begin
		oe_n_f_d = oe_n_f_q;
		for (int i = 0; i < OTR_OE_COUNT; i++) begin
			oe_n_f_d[i] = otr_agree(oe_n_s2_q[i], oe_n_s3_q[i],
				oe_n_f_q[i]);
		end
	end

	assign edge_clock_f_d = otr_agree(edge_clock_s2_q, edge_clock_s3_q,
		edge_clock_f_q);
	assign enable_n_f_d = otr_agree(enable_n_s2_q, enable_n_s3_q,
		enable_n_f_q);
	assign clear_n_f_d = otr_agree(clear_n_s2_q, clear_n_s3_q,
		clear_n_f_q);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			data_f_q <= DATA_IDLE;
			edge_clock_f_q <= CLOCK_IDLE;
			enable_n_f_q <= ENABLE_IDLE;
			clear_n_f_q <= CLEAR_IDLE;
			oe_n_f_q <= OE_IDLE;
		end else begin
			data_f_q <= data_f_d;
			edge_clock_f_q <= edge_clock_f_d;
			enable_n_f_q <= enable_n_f_d;
			clear_n_f_q <= clear_n_f_d;
			oe_n_f_q <= oe_n_f_d;
		end
	end

	// a rise counts on the edge where the filtered level leaves low
	assign clock_rise = edge_clock_f_d & ~edge_clock_f_q;
	assign clear_act = ~clear_n_f_d;
	assign load_ok = ~enable_n_f_d;

	// storage never looks at the output enables
	always_comb begin
		store_d = store_q;
		if (clear_act) begin
			store_d = '0;
		end else if (clock_rise && load_ok) begin
			store_d = data_f_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			store_q <= {WIDTH{OTR_STORE_RESET}};
		end else begin
			store_q <= store_d;
		end
	end

	// one enable decision for all bits
	assign drive_d = ~|oe_n_f_d;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			drive_q <= OTR_DRIVE_RESET;
		end else begin
			drive_q <= drive_d;
		end
	end

	assign bus_out = store_q;
	assign bus_oe = {WIDTH{drive_q}};
endmodule
`default_nettype wire

// >>> otr_asserts.sv
// bus-side assertions for the storage register
`default_nettype none
module otr_asserts(
	input wire logic clock, sys_rst, clear_n, enable_n, edge_clock,
	input wire logic [2:0] out_enable_n,
	input wire logic [7:0] data_in, bus_out, bus_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	AST_ALL: assert property (!bus_oe || &bus_oe)
		else $error("oe split");
	AST_ON: assert property ((out_enable_n == 3'h0)[*6] |-> &bus_oe)
		else $error("no drive");
	AST_OFF: assert property ((|out_enable_n)[*6] |-> !bus_oe)
		else $error("no float");
	AST_CLR: assert property ((!clear_n)[*6] |-> !bus_out)
		else $error("no clear");
	AST_HOLD: assert property ((enable_n && clear_n)[*8]
		|-> $stable(bus_out)) else $error("not held");
	AST_LOAD: assert property ((!enable_n && clear_n && !edge_clock
		&& $stable(data_in))[*4] ##1 (!enable_n && clear_n && edge_clock
		&& $stable(data_in))[*5] |-> bus_out == data_in)
		else $error("no load");
endmodule
bind otr_register otr_asserts chk(.clock, .sys_rst, .clear_n, .enable_n,
	.edge_clock, .out_enable_n, .data_in, .bus_out, .bus_oe);
`default_nettype wire

// >>> otr_bus_model.sv
// shared bus: driven bits show data, released bits float
`default_nettype none
module otr_bus_model(
	input wire logic [7:0] drv, en,
	output wire logic [7:0] bus
);
	for (genvar i = 0; i < 8; i++) assign bus[i] = en[i] ? drv[i] : 1'bz;
endmodule
`default_nettype wire

// >>> test_octal_tristate_register_clear.sv
// self-checking bench for the octal storage register
`default_nettype none
module test_octal_tristate_register_clear;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, sys_rst = 1, edge_clock = 0, enable_n = 0, clear_n = 1;
	logic [7:0] data_in = 8'h00, bus_out, bus_oe;
	logic [2:0] out_enable_n = 3'h0;
	wire [7:0] bus;
	int err_total = 0, n_tests = 0;
	otr_register dut(.clock, .sys_rst, .data_in, .edge_clock, .enable_n,
		.clear_n, .out_enable_n, .bus_out, .bus_oe);
	otr_bus_model far(.drv(bus_out), .en(bus_oe), .bus);
	initial forever #10 clock = ~clock;
	task step(int n);
		repeat (n) @(negedge clock);
	endtask
	task chk(string what, logic [7:0] exp);
		n_tests++;
		if (bus !== exp) begin
			err_total++;
			$display("wrong value %s exp %h got %h", what, exp, bus);
		end
	endtask
	task put(logic [7:0] d);
		data_in = d;
		step(5);
		edge_clock = 1;
		step(5);
		edge_clock = 0;
		step(6);
	endtask
	task sc_load;
		put(8'hA5);
		chk("load", 8'hA5);
		enable_n = 1;
		put(8'hC3);
		chk("hold", 8'hA5);
		enable_n = 0;
	endtask
	task sc_float;
		for (int i = 0; i < 3; i++) begin
			out_enable_n = 3'h1 << i;
			put(8'h3C);
			chk("float", 8'hZZ);
		end
		out_enable_n = 3'h0;
		step(6);
		chk("kept", 8'h3C);
	endtask
	task sc_clear;
		clear_n = 0;
		put(8'h99);
		chk("clear", 8'h00);
		clear_n = 1;
		put(8'h66);
		chk("after", 8'h66);
	endtask
	task tally_and_finish;
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		step(6);
		sys_rst = 0;
		step(2);
		sc_load;
		sc_float;
		sc_clear;
		tally_and_finish;
	end
endmodule
`default_nettype wire
